// *** pkg/fbe_pkg.sv ***
// Shared constants and carriers of the flash block erase/program interface.
// Assumes an 8-bit register port and a flash macro that signals completion.
package fbe_pkg;

  // ************************************************************
  // Array geometry
  // ************************************************************
  localparam int ADDR_W = 19;
  localparam int UNIT_BYTES = 128;
  localparam int NUM_BLOCKS = 16;
  localparam logic [18:0] SMALL_BASE = 19'h00000;
  localparam logic [18:0] SMALL_SZ = 19'h01000;
  localparam logic [18:0] MID_BASE = 19'h04000;
  localparam logic [18:0] MID_SZ = 19'h08000;
  localparam logic [18:0] UPPER_SMALL_BASE = 19'h0C000;
  localparam logic [18:0] BIG_BASE = 19'h10000;
  localparam logic [18:0] BIG_SZ = 19'h10000;
  localparam logic [18:0] ARR_TOP = 19'h7FFFF;
  localparam logic [3:0] BLK_MID = 4'h4;
  localparam logic [3:0] BLK_UPPER_SMALL = 4'h5;
  localparam logic [3:0] BLK_BIG = 4'h9;

  // ************************************************************
  // Register offsets
  // ************************************************************
  localparam logic [7:0] OFS_STC = 8'h00;
  localparam logic [7:0] OFS_CCS = 8'h01;
  localparam logic [7:0] OFS_PSEL = 8'h02;
  localparam logic [7:0] OFS_ESEL = 8'h03;
  localparam logic [7:0] OFS_KEY = 8'h04;
  localparam logic [7:0] OFS_TDAR = 8'h05;
  localparam logic [7:0] OFS_DLRES = 8'h06;
  localparam logic [7:0] OFS_FREQ = 8'h07;
  localparam logic [7:0] OFS_PFRES = 8'h08;
  localparam logic [7:0] OFS_ADDR0 = 8'h09;
  localparam logic [7:0] OFS_ADDR1 = 8'h0A;
  localparam logic [7:0] OFS_ADDR2 = 8'h0B;
  localparam logic [7:0] OFS_EBLK = 8'h0C;
  localparam logic [7:0] OFS_IDX = 8'h0D;
  localparam logic [7:0] OFS_DATA = 8'h0E;
  localparam logic [7:0] OFS_CALL = 8'h0F;
  localparam logic [7:0] OFS_STATUS = 8'h10;

  // ************************************************************
  // Fields, keys, codes, reset values
  // ************************************************************
  localparam int FAE_BIT = 0;
  localparam int WEF_BIT = 7;
  localparam int DSB_BIT = 0;
  localparam int SEL_BIT = 0;
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [7:0] KEY_DL = 8'hA5;
  localparam logic [7:0] KEY_PE = 8'h5A;
  localparam logic [7:0] CALL_INIT = 8'h01;
  localparam logic [7:0] CALL_PROG = 8'h02;
  localparam logic [7:0] CALL_ERASE = 8'h03;
  localparam logic [7:0] RES_PASS = 8'h00;
  localparam logic [7:0] RES_KEY = 8'h01;
  localparam logic [7:0] RES_SEL = 8'h02;
  localparam logic [7:0] RES_ADDR = 8'h04;
  localparam logic [7:0] RES_FLASH = 8'h08;
  localparam logic [7:0] RES_NOINIT = 8'h10;
  localparam logic [7:0] RES_BLK = 8'h20;
  localparam logic [7:0] RES_FREQ = 8'h40;
  localparam logic [6:0] DL_LAST = 7'h0F;
  localparam logic [6:0] UNIT_LAST = 7'h7F;
  // Arbitrary tags for the routine image words
  localparam logic [7:0] IMG_PROG = 8'h50;
  localparam logic [7:0] IMG_ERASE = 8'hE0;

  // ************************************************************
  // Carriers
  // ************************************************************
  typedef struct packed {
    logic wr_en;
    logic commit;
    logic erase;
    logic [18:0] addr;
    logic [18:0] last;
    logic [7:0] wdata;
  } fbe_arr_s;

  typedef struct packed {
    logic wr_en;
    logic [15:0] addr;
    logic [15:0] data;
  } fbe_ram_s;

  typedef enum {ST_IDLE, ST_DLOAD, ST_PROG, ST_COMMIT, ST_ERASE, ST_WAIT} fbe_state_e;

endpackage

// *** core/fbe_pgbuf.sv ***
// Holds the 128-byte programming unit written by software.
// Assumes one write port and one read port on the same clock.
`timescale 1ns/1ps
module fbe_pgbuf (
  input wire logic core_clk,
  input wire logic wr_en,
  input wire logic [6:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [6:0] rd_addr,
  output logic [7:0] rd_data_r
);

  logic [7:0] mem [0:127];

  // Write port; no reset, contents are defined by software
  always_ff @(posedge core_clk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Registered read, one cycle latency
  always_ff @(posedge core_clk)
  begin
    rd_data_r <= mem[rd_addr];
  end

endmodule

// *** core/fbe_blkmap.sv ***
// Maps an erase block number onto its first and last array byte.
// Purely combinational; the caller registers the results.
`timescale 1ns/1ps
module fbe_blkmap (
  input wire logic [7:0] blk,
  output logic [18:0] base,
  output logic [18:0] last,
  output logic valid
);

  logic [18:0] n;

  // Block layout of the user array
  always_comb
  begin
    n = {15'h0, blk[3:0]};
    valid = (blk < 8'(fbe_pkg::NUM_BLOCKS)); // [RQ2] [RQ21]
    base = fbe_pkg::SMALL_BASE;
    last = fbe_pkg::SMALL_SZ - 19'h1;
    if (blk[3:0] < fbe_pkg::BLK_MID)
    begin
      base = fbe_pkg::SMALL_BASE + 19'(n * fbe_pkg::SMALL_SZ); // [RQ3] [RQ1]
      last = base + fbe_pkg::SMALL_SZ - 19'h1;
    end
    else if (blk[3:0] == fbe_pkg::BLK_MID)
    begin
      base = fbe_pkg::MID_BASE; // [RQ4]
      last = base + fbe_pkg::MID_SZ - 19'h1;
    end
    else if (blk[3:0] < fbe_pkg::BLK_BIG)
    begin
      base = fbe_pkg::UPPER_SMALL_BASE
        + 19'((n - 19'(fbe_pkg::BLK_UPPER_SMALL)) * fbe_pkg::SMALL_SZ); // [RQ5]
      last = base + fbe_pkg::SMALL_SZ - 19'h1;
    end
    else
    begin
      base = fbe_pkg::BIG_BASE
        + 19'((n - 19'(fbe_pkg::BLK_BIG)) * fbe_pkg::BIG_SZ); // [RQ6]
      last = base + fbe_pkg::BIG_SZ - 19'h1;
    end
  end

endmodule

// *** core/fbe_top.sv ***
// Flash programming/erasing sequencer: register file, routine download,
// 128-byte programming and block erase toward the flash array macro.
// Assumes the array macro pulses arr_done (with arr_fail) on its clock.
// Summary of operation
// [RQ1] Array splits into sixteen blocks: seven 64K, one 32K, eight 4K.
// [RQ2] Each erase names one block, number 0 to 15, chosen by software.
// [RQ3] Blocks 0 to 3 are 4K each from 0x000000 to 0x003FFF.
// [RQ4] Block 4 is 32K after block 3, last unit at 0x00BF80.
// [RQ5] Blocks 5 to 8 are 4K from 0x00C000, last unit 0x00FF80.
// [RQ6] Blocks 9 to 15 are 64K from 0x010000 up to 0x07FFFF.
// [RQ7] Programming moves 128 bytes to one software-given destination address.
// [RQ8] Software sets flash access enable before any download or operation.
// [RQ9] Routine chosen by select bits; RAM destination in transfer register.
// [RQ10] Key code plus start bit copies the chosen routine into RAM.
// [RQ11] During download the embedded store replaces the user array in the map.
// [RQ12] Array unreadable while busy; software runs from RAM.
// [RQ13] Download outcome lands in the download result parameter.
// [RQ14] Software runs initialisation with a frequency before any operation.
// [RQ15] Software calls the routine after writing address, data or block.
// [RQ16] Each program or erase call leaves its outcome in the result parameter.
// [RQ17] Software erases before programming and masks interrupts throughout.
// [RQ18] Software repeats calls per unit or block with updated parameters.
// [RQ19] Routine stays resident; repeats need no new download or initialisation.
// [RQ20] Write enable flag always reads as one and ignores writes.
// [RQ21] Erase with block number above 15 fails and leaves the array alone.
//
// Design decisions made here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
module fbe_top (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata_r,
  output fbe_pkg::fbe_arr_s arr_out_r,
  input wire logic arr_done,
  input wire logic arr_fail,
  output fbe_pkg::fbe_ram_s ram_out_r,
  output logic embed_map_r,
  output logic array_locked_r
);

  // ************************************************************
  // Declarations
  // ************************************************************
  fbe_pkg::fbe_state_e state_r;
  logic fae_r;
  logic psel_r;
  logic esel_r;
  logic [7:0] key_r;
  logic [7:0] tdar_r;
  logic [7:0] freq_r;
  logic [18:0] paddr_r;
  logic [7:0] eblk_r;
  logic [6:0] idx_r;
  logic [7:0] dlres_r;
  logic [7:0] pfres_r;
  logic dl_prog_r;
  logic dl_erase_r;
  logic dl_kind_r;
  logic init_r;
  logic [6:0] cnt_r;
  logic [18:0] base_r;
  logic [18:0] last_r;
  logic rd_vld_r;
  logic [6:0] rd_off_r;
  logic commit_req_r;
  logic erase_req_r;
  logic wr_ok;
  logic rd_ok;
  logic buf_we;
  logic start_wr;
  logic call_wr;
  logic [7:0] buf_q;
  logic [18:0] blk_base;
  logic [18:0] blk_last;
  logic blk_valid;
  logic [7:0] rd_mux;

  // Access is gated by the flash access enable, except its own register and reads of CCS
  assign wr_ok = reg_wr && (fae_r || reg_addr == fbe_pkg::OFS_STC); // [RQ8]
  assign rd_ok = reg_rd && (fae_r || reg_addr == fbe_pkg::OFS_STC
    || reg_addr == fbe_pkg::OFS_CCS);
  assign start_wr = wr_ok && reg_addr == fbe_pkg::OFS_CCS && reg_wdata[fbe_pkg::DSB_BIT];
  assign call_wr = wr_ok && reg_addr == fbe_pkg::OFS_CALL;
  // Buffer is frozen while a unit is being streamed out
  assign buf_we = wr_ok && reg_addr == fbe_pkg::OFS_DATA && state_r == fbe_pkg::ST_IDLE;

  // ************************************************************
  // Submodules
  // ************************************************************
  fbe_pgbuf u_pgbuf (
    .core_clk(core_clk),
    .wr_en(buf_we),
    .wr_addr(idx_r),
    .wr_data(reg_wdata),
    .rd_addr(cnt_r),
    .rd_data_r(buf_q)
  );

  fbe_blkmap u_blkmap (
    .blk(eblk_r),
    .base(blk_base),
    .last(blk_last),
    .valid(blk_valid)
  );

  // ************************************************************
  // Software-written configuration
  // ************************************************************
  // Plain storage registers; the write enable flag has no storage at all
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      fae_r <= 1'b0;
      psel_r <= 1'b0;
      esel_r <= 1'b0;
      key_r <= fbe_pkg::RST_REG;
      tdar_r <= fbe_pkg::RST_REG;
      freq_r <= fbe_pkg::RST_REG;
      paddr_r <= 19'h0;
      eblk_r <= fbe_pkg::RST_REG;
    end
    else if (wr_ok)
    begin
      case (reg_addr)
        fbe_pkg::OFS_STC: fae_r <= reg_wdata[fbe_pkg::FAE_BIT];
        fbe_pkg::OFS_PSEL: psel_r <= reg_wdata[fbe_pkg::SEL_BIT]; // [RQ9]
        fbe_pkg::OFS_ESEL: esel_r <= reg_wdata[fbe_pkg::SEL_BIT]; // [RQ9]
        fbe_pkg::OFS_KEY: key_r <= reg_wdata;
        fbe_pkg::OFS_TDAR: tdar_r <= reg_wdata; // [RQ9]
        fbe_pkg::OFS_FREQ: freq_r <= reg_wdata; // [RQ14]
        fbe_pkg::OFS_ADDR0: paddr_r[7:0] <= reg_wdata;
        fbe_pkg::OFS_ADDR1: paddr_r[15:8] <= reg_wdata;
        fbe_pkg::OFS_ADDR2: paddr_r[18:16] <= reg_wdata[2:0];
        fbe_pkg::OFS_EBLK: eblk_r <= reg_wdata; // [RQ2]
        default: ;
      endcase
    end
  end

  // Buffer index: set directly, advanced by each data write taken in idle (wraps at 128)
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      idx_r <= 7'h0;
    end
    else if (wr_ok && reg_addr == fbe_pkg::OFS_IDX)
    begin
      idx_r <= reg_wdata[6:0];
    end
    else if (buf_we)
    begin
      idx_r <= idx_r + 7'h1; // [RQ7]
    end
  end

  // ************************************************************
  // Sequencer
  // ************************************************************
  // Download, initialisation and program/erase calls; one at a time
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_r <= fbe_pkg::ST_IDLE;
      cnt_r <= 7'h0;
      dlres_r <= fbe_pkg::RES_PASS;
      pfres_r <= fbe_pkg::RES_PASS;
      dl_prog_r <= 1'b0;
      dl_erase_r <= 1'b0;
      dl_kind_r <= 1'b0;
      init_r <= 1'b0;
      base_r <= 19'h0;
      last_r <= 19'h0;
      commit_req_r <= 1'b0;
      erase_req_r <= 1'b0;
    end
    else
    begin
      commit_req_r <= 1'b0;
      erase_req_r <= 1'b0;
      case (state_r)
        fbe_pkg::ST_IDLE:
        begin
          cnt_r <= 7'h0;
          if (start_wr)
          begin
            if (key_r != fbe_pkg::KEY_DL)
            begin
              dlres_r <= fbe_pkg::RES_KEY; // [RQ13]
            end
            else if (psel_r == esel_r)
            begin
              dlres_r <= fbe_pkg::RES_SEL; // [RQ9] [RQ13]
            end
            else
            begin
              dl_kind_r <= psel_r;
              if (psel_r)
              begin
                dl_prog_r <= 1'b0;
              end
              else
              begin
                dl_erase_r <= 1'b0;
              end
              state_r <= fbe_pkg::ST_DLOAD; // [RQ10]
            end
          end
          else if (call_wr && reg_wdata == fbe_pkg::CALL_INIT)
          begin
            // A zero frequency cannot time anything, so it is refused
            if (freq_r == fbe_pkg::RST_REG)
            begin
              pfres_r <= fbe_pkg::RES_FREQ;
            end
            else
            begin
              init_r <= 1'b1; // [RQ14] [RQ19]
              pfres_r <= fbe_pkg::RES_PASS;
            end
          end
          else if (call_wr && reg_wdata == fbe_pkg::CALL_PROG)
          begin
            if (!dl_prog_r || !init_r)
            begin
              pfres_r <= fbe_pkg::RES_NOINIT; // [RQ16]
            end
            else if (key_r != fbe_pkg::KEY_PE)
            begin
              pfres_r <= fbe_pkg::RES_KEY;
            end
            else if (paddr_r[6:0] != 7'h0)
            begin
              pfres_r <= fbe_pkg::RES_ADDR; // [RQ7]
            end
            else
            begin
              base_r <= paddr_r; // [RQ15] [RQ18]
              state_r <= fbe_pkg::ST_PROG;
            end
          end
          else if (call_wr && reg_wdata == fbe_pkg::CALL_ERASE)
          begin
            if (!dl_erase_r || !init_r)
            begin
              pfres_r <= fbe_pkg::RES_NOINIT; // [RQ16]
            end
            else if (key_r != fbe_pkg::KEY_PE)
            begin
              pfres_r <= fbe_pkg::RES_KEY;
            end
            else if (!blk_valid)
            begin
              pfres_r <= fbe_pkg::RES_BLK; // [RQ21]
            end
            else
            begin
              base_r <= blk_base; // [RQ2] [RQ15]
              last_r <= blk_last;
              state_r <= fbe_pkg::ST_ERASE;
            end
          end
        end
        fbe_pkg::ST_DLOAD:
        begin
          cnt_r <= cnt_r + 7'h1;
          if (cnt_r == fbe_pkg::DL_LAST)
          begin
            dlres_r <= fbe_pkg::RES_PASS; // [RQ13]
            dl_prog_r <= dl_prog_r | dl_kind_r; // [RQ19]
            dl_erase_r <= dl_erase_r | ~dl_kind_r;
            state_r <= fbe_pkg::ST_IDLE;
          end
        end
        fbe_pkg::ST_PROG:
        begin
          cnt_r <= cnt_r + 7'h1; // [RQ7]
          if (cnt_r == fbe_pkg::UNIT_LAST)
          begin
            state_r <= fbe_pkg::ST_COMMIT;
          end
        end
        fbe_pkg::ST_COMMIT:
        begin
          // Last byte leaves at this edge, commit follows it
          commit_req_r <= 1'b1;
          state_r <= fbe_pkg::ST_WAIT;
        end
        fbe_pkg::ST_ERASE:
        begin
          erase_req_r <= 1'b1;
          state_r <= fbe_pkg::ST_WAIT;
        end
        fbe_pkg::ST_WAIT:
        begin
          if (arr_done)
          begin
            pfres_r <= arr_fail ? fbe_pkg::RES_FLASH : fbe_pkg::RES_PASS; // [RQ16]
            state_r <= fbe_pkg::ST_IDLE;
          end
        end
        default: state_r <= fbe_pkg::ST_IDLE;
      endcase
    end
  end

  // Read pipeline of the unit buffer: data appear one cycle after the index
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rd_vld_r <= 1'b0;
      rd_off_r <= 7'h0;
    end
    else
    begin
      rd_vld_r <= (state_r == fbe_pkg::ST_PROG);
      rd_off_r <= cnt_r;
    end
  end

  // ************************************************************
  // Outputs toward array, RAM and address map
  // ************************************************************
  // Array strobes; a failed erase check never reaches this point
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      arr_out_r <= '0;
    end
    else
    begin
      arr_out_r.wr_en <= rd_vld_r; // [RQ7]
      arr_out_r.commit <= commit_req_r;
      arr_out_r.erase <= erase_req_r; // [RQ2] [RQ21]
      arr_out_r.addr <= rd_vld_r ? (base_r | {12'h0, rd_off_r}) : base_r;
      arr_out_r.last <= rd_vld_r ? base_r + 19'(fbe_pkg::UNIT_BYTES - 1) : last_r;
      arr_out_r.wdata <= rd_vld_r ? buf_q : fbe_pkg::RST_REG;
    end
  end

  // Routine copy into RAM at the transfer destination
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ram_out_r <= '0;
    end
    else
    begin
      ram_out_r.wr_en <= (state_r == fbe_pkg::ST_DLOAD); // [RQ10]
      ram_out_r.addr <= {tdar_r, 1'b0, cnt_r}; // [RQ9]
      ram_out_r.data <= {dl_kind_r ? fbe_pkg::IMG_PROG : fbe_pkg::IMG_ERASE, 1'b0, cnt_r};
    end
  end

  // Map select and array lock
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      embed_map_r <= 1'b0;
      array_locked_r <= 1'b0;
    end
    else
    begin
      embed_map_r <= (state_r == fbe_pkg::ST_DLOAD); // [RQ11]
      array_locked_r <= (state_r != fbe_pkg::ST_IDLE); // [RQ12]
    end
  end

  // ************************************************************
  // Register read-back
  // ************************************************************
  // Read mux; unmapped and write-only offsets read as zero
  always_comb
  begin
    rd_mux = fbe_pkg::RST_REG;
    case (reg_addr)
      fbe_pkg::OFS_STC: rd_mux = {7'h0, fae_r};
      fbe_pkg::OFS_CCS: rd_mux = {1'b1, 6'h0, state_r == fbe_pkg::ST_DLOAD}; // [RQ20]
      fbe_pkg::OFS_PSEL: rd_mux = {7'h0, psel_r};
      fbe_pkg::OFS_ESEL: rd_mux = {7'h0, esel_r};
      fbe_pkg::OFS_KEY: rd_mux = key_r;
      fbe_pkg::OFS_TDAR: rd_mux = tdar_r;
      fbe_pkg::OFS_DLRES: rd_mux = dlres_r;
      fbe_pkg::OFS_FREQ: rd_mux = freq_r;
      fbe_pkg::OFS_PFRES: rd_mux = pfres_r;
      fbe_pkg::OFS_ADDR0: rd_mux = paddr_r[7:0];
      fbe_pkg::OFS_ADDR1: rd_mux = paddr_r[15:8];
      fbe_pkg::OFS_ADDR2: rd_mux = {5'h0, paddr_r[18:16]};
      fbe_pkg::OFS_EBLK: rd_mux = eblk_r;
      fbe_pkg::OFS_IDX: rd_mux = {1'b0, idx_r};
      fbe_pkg::OFS_STATUS: rd_mux = {4'h0, init_r, dl_erase_r, dl_prog_r, array_locked_r};
      default: rd_mux = fbe_pkg::RST_REG;
    endcase
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      reg_rdata_r <= fbe_pkg::RST_REG;
    end
    else
    begin
      reg_rdata_r <= rd_ok ? rd_mux : fbe_pkg::RST_REG;
    end
  end

endmodule

// *** bench/fbe_chk.sv ***
// Port checker for the flash sequencer top.
// Assumes one clock; bound to fbe_top below.
`timescale 1ns/1ps
module fbe_chk (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata_r,
  input wire fbe_pkg::fbe_arr_s arr_out_r,
  input wire fbe_pkg::fbe_ram_s ram_out_r,
  input wire logic embed_map_r,
  input wire logic array_locked_r
);
  // ***
  // Timing and geometry
  // ***
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  logic [18:0] ea, el;
  // Address pair
  assign ea = arr_out_r.addr;
  assign el = arr_out_r.last;
  a_rd_quiet: assert property (
    !$past(reg_rd) |-> reg_rdata_r == 8'h00)
    else $error("stray read data");
  a_wef_one: assert property (
    reg_rd && reg_addr == fbe_pkg::OFS_CCS |=> reg_rdata_r[7])
    else $error("flag read low");
  a_unit_end: assert property (
    arr_out_r.wr_en |-> el == (ea | 19'h7F))
    else $error("unit end");
  a_byte_order: assert property (
    arr_out_r.wr_en && ea[6:0] != 7'h7F |=> arr_out_r.wr_en && ea == $past(ea) + 19'h1)
    else $error("byte order");
  a_erase_span: assert property (
    arr_out_r.erase |-> ea[11:0] == 12'h000 && (
    (ea < 19'h4000 && el == ea + 19'hFFF) || (ea == 19'h4000 && el == 19'hBFFF)
    || (ea >= 19'hC000 && ea < 19'h10000 && el == ea + 19'hFFF)
    || (ea >= 19'h10000 && ea[15:0] == 16'h0000 && el == ea + 19'hFFFF)))
    else $error("erase bounds");
  a_busy_lock: assert property (
    arr_out_r.wr_en || arr_out_r.erase || arr_out_r.commit |-> array_locked_r)
    else $error("access unlocked");
  a_embed_lock: assert property (embed_map_r |-> array_locked_r)
    else $error("map unlocked");
  a_dl_words: assert property (ram_out_r.wr_en == embed_map_r)
    else $error("stray download word");
  a_dl_len: assert property (
    $rose(embed_map_r) |-> ##15 embed_map_r ##1 !embed_map_r)
    else $error("download length");
  a_image_tag: assert property (
    ram_out_r.wr_en |-> ram_out_r.data[3:0] == ram_out_r.addr[3:0] &&
    (ram_out_r.data[15:8] == fbe_pkg::IMG_PROG || ram_out_r.data[15:8] == fbe_pkg::IMG_ERASE))
    else $error("image word");
endmodule
bind fbe_top fbe_chk u_chk (.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
  .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r), .arr_out_r(arr_out_r), .ram_out_r(ram_out_r),
  .embed_map_r(embed_map_r), .array_locked_r(array_locked_r));

// *** bench/fbe_flash_model.sv ***
// Flash array model: answers commit and erase, records traffic.
// Assumes the sequencer's clock.
`timescale 1ns/1ps
module fbe_flash_model (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire fbe_pkg::fbe_arr_s arr_in,
  input wire logic slow,
  input wire logic fail_req,
  output logic arr_done,
  output logic arr_fail
);
  // ***
  // Completion and record
  // ***
  logic [7:0] wait_r, sum;
  logic busy_r;
  logic [18:0] ers_base, ers_last, first;
  int ers_cnt = 0, bcnt = 0;
  // Fail toggles in every cycle without a request or completion, idle or waiting, to expose stale samples
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      busy_r <= 1'b0;
      arr_done <= 1'b0;
      arr_fail <= 1'b0;
      wait_r <= 8'h00;
    end
    else if (arr_in.commit || arr_in.erase)
    begin
      busy_r <= 1'b1;
      wait_r <= slow ? 8'h28 : 8'h01;
    end
    else if (busy_r && wait_r == 8'h00)
    begin
      busy_r <= 1'b0;
      arr_done <= 1'b1;
      arr_fail <= fail_req;
    end
    else
    begin
      wait_r <= wait_r - 8'h01;
      arr_done <= 1'b0;
      arr_fail <= ~arr_fail;
    end
  end
  // Erase record; unit byte sum
  always_ff @(posedge core_clk)
  begin
    if (arr_in.erase)
    begin
      ers_base <= arr_in.addr;
      ers_last <= arr_in.last;
      ers_cnt <= ers_cnt + 1;
    end
    if (arr_in.wr_en)
    begin
      first <= arr_in.addr[6:0] == 7'h00 ? arr_in.addr : first;
      sum <= (arr_in.addr[6:0] == 7'h00 ? 8'h00 : sum) + arr_in.wdata;
      bcnt <= arr_in.addr[6:0] == 7'h00 ? 1 : bcnt + 1;
    end
  end
endmodule

// *** bench/fbe_top_tb.sv ***
// Bench: register tasks drive download, erase and program calls.
// Assumes the flash model and the bound checker.
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fails++; \
  $display("Error at %0t: got %0h exp %0h", $time, g, e); end end
module fbe_top_tb;
  // ***
  // Signals and instances
  // ***
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_rdata_r;
  fbe_pkg::fbe_arr_s arr_out_r;
  fbe_pkg::fbe_ram_s ram_out_r;
  logic arr_done, arr_fail, embed_map_r, array_locked_r;
  logic slow = 1'b0, fail_req = 1'b0;
  int fails = 0, checked = 0, ram_cnt = 0;
  int ecnt;
  logic [15:0] ram_last;
  logic [18:0] base, last;
  fbe_top dut (.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r),
    .arr_out_r(arr_out_r), .arr_done(arr_done), .arr_fail(arr_fail),
    .ram_out_r(ram_out_r), .embed_map_r(embed_map_r), .array_locked_r(array_locked_r));
  fbe_flash_model u_arr (.core_clk(core_clk), .sys_rst(sys_rst), .arr_in(arr_out_r),
    .slow(slow), .fail_req(fail_req), .arr_done(arr_done), .arr_fail(arr_fail));
  always #5 core_clk = ~core_clk;
  // Download word tally
  always @(posedge core_clk)
  begin
    if (ram_out_r.wr_en === 1'b1)
    begin
      ram_cnt++;
      ram_last = ram_out_r.addr;
    end
  end
  // ***
  // Register port tasks
  // ***
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // Data stand in the cycle after the strobe
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 `CHK(reg_rdata_r, e)
  endtask
  // Bounded wait; a hang counts as a mismatch
  task automatic op(input logic [7:0] c, input logic [7:0] res);
    int n;
    n = 0;
    if (c != 8'h00)
      wr(fbe_pkg::OFS_CALL, c);
    repeat (3) @(posedge core_clk);
    while (array_locked_r !== 1'b0 && n < 600)
    begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 600)
      fails++;
    if (c != 8'h00)
      rdc(fbe_pkg::OFS_PFRES, res);
  endtask
  task automatic dl(input logic [7:0] ps, input logic [7:0] es);
    wr(fbe_pkg::OFS_PSEL, ps);
    wr(fbe_pkg::OFS_ESEL, es);
    wr(fbe_pkg::OFS_KEY, fbe_pkg::KEY_DL);
    wr(fbe_pkg::OFS_TDAR, 8'h20);
    ram_cnt = 0;
    wr(fbe_pkg::OFS_CCS, 8'h01);
    op(8'h00, 8'h00);
    rdc(fbe_pkg::OFS_DLRES, fbe_pkg::RES_PASS);
    `CHK(ram_cnt, 16)
    `CHK(ram_last, 16'h200F)
  endtask
  task automatic prog(input logic [18:0] a, input logic [7:0] res);
    logic [7:0] s;
    s = 8'h00;
    wr(fbe_pkg::OFS_IDX, 8'h00);
    for (int i = 0; i < 128; i++)
    begin
      wr(fbe_pkg::OFS_DATA, 8'(i * 5 + 1));
      s = s + 8'(i * 5 + 1);
    end
    for (int k = 0; k < 3; k++)
      wr(8'(fbe_pkg::OFS_ADDR0 + k), 8'(a >> (8 * k)));
    op(fbe_pkg::CALL_PROG, res);
    if (res == fbe_pkg::RES_PASS)
    begin
      `CHK(u_arr.first, a)
      `CHK(u_arr.bcnt, 128)
      `CHK(u_arr.sum, s)
    end
  endtask
  task automatic print_verdict();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // ***
  // Scenarios
  // ***
  initial
  begin
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b0;
    rdc(fbe_pkg::OFS_CCS, 8'h80);
    wr(fbe_pkg::OFS_FREQ, 8'h20);
    wr(fbe_pkg::OFS_STC, 8'h01);
    wr(fbe_pkg::OFS_CCS, 8'h00);
    rdc(fbe_pkg::OFS_CCS, 8'h80);
    rdc(fbe_pkg::OFS_FREQ, 8'h00);
    $display("registers test done");
    wr(fbe_pkg::OFS_PSEL, 8'h01);
    wr(fbe_pkg::OFS_CCS, 8'h01);
    op(8'h00, 8'h00);
    rdc(fbe_pkg::OFS_DLRES, fbe_pkg::RES_KEY);
    wr(fbe_pkg::OFS_ESEL, 8'h01);
    wr(fbe_pkg::OFS_KEY, fbe_pkg::KEY_DL);
    wr(fbe_pkg::OFS_CCS, 8'h01);
    op(8'h00, 8'h00);
    rdc(fbe_pkg::OFS_DLRES, fbe_pkg::RES_SEL);
    wr(fbe_pkg::OFS_KEY, fbe_pkg::KEY_PE);
    op(fbe_pkg::CALL_PROG, fbe_pkg::RES_NOINIT);
    dl(8'h01, 8'h00);
    dl(8'h00, 8'h01);
    rdc(fbe_pkg::OFS_STATUS, 8'h06);
    $display("download test done");
    wr(fbe_pkg::OFS_FREQ, 8'h00);
    op(fbe_pkg::CALL_INIT, fbe_pkg::RES_FREQ);
    wr(fbe_pkg::OFS_FREQ, 8'h20);
    op(fbe_pkg::CALL_INIT, fbe_pkg::RES_PASS);
    wr(fbe_pkg::OFS_KEY, fbe_pkg::KEY_PE);
    // All blocks, then a bad one; odd ones slow
    for (int b = 0; b < 17; b++)
    begin
      base = b < 4 ? 19'(b * 4096) : b == 4 ? 19'h04000 : b < 9 ? 19'(32'hC000 + (b - 5) * 4096)
        : 19'(32'h10000 + (b - 9) * 65536);
      last = base + (b == 4 ? 19'h07FFF : b < 9 ? 19'h00FFF : 19'h0FFFF);
      slow <= b[0];
      fail_req <= (b == 7);
      ecnt = u_arr.ers_cnt;
      wr(fbe_pkg::OFS_EBLK, 8'(b));
      op(fbe_pkg::CALL_ERASE, b == 16 ? fbe_pkg::RES_BLK : b == 7 ? fbe_pkg::RES_FLASH
        : fbe_pkg::RES_PASS);
      `CHK(u_arr.ers_cnt, ecnt + (b < 16 ? 1 : 0))
      if (b < 16)
      begin
        `CHK(u_arr.ers_base, base)
        `CHK(u_arr.ers_last, last)
      end
    end
    fail_req <= 1'b0;
    $display("erase test done");
    prog(19'h0BF80, fbe_pkg::RES_PASS);
    prog(19'h0FF80, fbe_pkg::RES_PASS);
    prog(19'h7FF80, fbe_pkg::RES_PASS);
    prog(19'h0BF81, fbe_pkg::RES_ADDR);
    wr(fbe_pkg::OFS_ADDR0, 8'h80);
    wr(fbe_pkg::OFS_KEY, 8'h00);
    op(fbe_pkg::CALL_PROG, fbe_pkg::RES_KEY);
    $display("program test done");
    print_verdict();
  end
  // Run takes under 20000 cycles
  initial
  begin
    #300us;
    fails++;
    print_verdict();
  end
endmodule
